//--- core/fspc_pkg.sv
// package: register map, control bit layout, region map and timing for the flash controller
package fspc_pkg;
  localparam logic [3:0] ADDR_DATA_LOW   = 4'h0;
  localparam logic [3:0] ADDR_DATA_HIGH  = 4'h1;
  localparam logic [3:0] ADDR_ADDR_LOW   = 4'h2;
  localparam logic [3:0] ADDR_ADDR_HIGH  = 4'h3;
  localparam logic [3:0] ADDR_CONTROL    = 4'h4;
  localparam logic [3:0] ADDR_UNLOCK_KEY = 4'h5;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h6;
  localparam logic [3:0] ADDR_IRQ_MASK   = 4'h7;
  localparam logic [3:0] ADDR_PROTECT    = 4'h8;

  localparam int BIT_REGION     = 6;
  localparam int BIT_LATCH_ONLY = 5;
  localparam int BIT_ERASE      = 4;
  localparam int BIT_FAULT      = 3;
  localparam int BIT_PERMIT     = 2;
  localparam int BIT_WRITE      = 1;
  localparam int BIT_READ       = 0;

  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;

  localparam int ADDR_W     = 15;
  localparam int DATA_W     = 14;
  localparam int ROW_WORDS  = 32;
  localparam int ROW_BITS   = 5;
  localparam int ARRAY_WORDS = 1024;
  localparam int ARRAY_BITS  = 10;
  localparam logic [DATA_W-1:0] ERASED_WORD = 14'h3FFF;
  localparam logic [DATA_W-1:0] LATCH_RESET = 14'h03FF;
  localparam logic [6:0] ADDR_HIGH_FILL = 7'h00;

  localparam int USER_ID_WORDS = 4;
  localparam logic [14:0] USER_ID_BASE = 15'h0000;
  localparam logic [14:0] USER_ID_LAST = 15'h0003;
  localparam logic [14:0] INFO_RO_BASE = 15'h0005;
  localparam logic [14:0] INFO_RO_LAST = 15'h000B;
  localparam logic [14:0] DIA_BASE     = 15'h0100;
  localparam logic [14:0] DIA_LAST     = 15'h02FF;
  localparam logic [DATA_W-1:0] INFO_FILL = 14'h3FFF;

  localparam int  CLK_MHZ    = 25;
  localparam int  PROG_NS    = 2000;
  localparam int  PROG_CYCLES = (PROG_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] PROG_COUNT = 8'(PROG_CYCLES);

  typedef enum logic [1:0] {
    FS_IDLE  = 2'b00,
    FS_ARMED = 2'b01,
    FS_BUSY  = 2'b11
  } fspc_state_t;

  typedef enum logic [1:0] {
    KEY_NONE = 2'b00,
    KEY_HALF = 2'b01,
    KEY_FULL = 2'b11
  } fspc_key_t;
endpackage

//--- core/fspc_top.sv
// flash self-program controller: registers, unlock, row latches, array model, interrupt
// How it works
// - region bit selects info area or array
// - latch-only write just loads row latch
// - erase clears whole 32-word row, self-clears
// - fault on reset of at most two cycles mid-write, broken unlock, protected
// - fault only software-cleared, software may set
// - program/erase only while permit bit set
// - write bit sets only after unlock
// - operations self-timed, write bit hardware-cleared
// - writing zero to busy write ignored
// - read fetches word next cycle, self-clears
// - read bit only settable by software
// - unlock is 55h then AAh then start
// - key write-only, resets zero, not stored
// - 15-bit address, high top bit reads one
// - high address and fault undefined while busy
// - 14-bit data, high byte top bits zero
// - invalid info read clears data pair
// - latches reset 3FFh; protected row faults
module fspc_top
  import fspc_pkg::*;
(
  input  wire logic       CLK_SYS,
  input  wire logic       RESET,
  input  wire logic [3:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR_STB,
  input  wire logic       RD_STB,
  output logic      [7:0] RDATA,
  output logic            IRQ
);
  logic [7:0]        data_low;
  logic [5:0]        data_high;
  logic [7:0]        addr_low;
  logic [6:0]        addr_high;
  logic              region;
  logic              latch_only;
  logic              erase;
  logic              fault;
  logic              permit;
  logic              write_busy;
  logic              read_go;
  logic              done_flag;
  logic              done_mask;
  logic [7:0]        protect_rows;
  logic [7:0]        timer;
  logic              was_busy_at_reset;
  fspc_state_t       state;
  fspc_key_t         key;
  logic [DATA_W-1:0] row_latch [ROW_WORDS];
  logic [DATA_W-1:0] array_mem [ARRAY_WORDS];
  logic [DATA_W-1:0] user_id [USER_ID_WORDS];

  wire [ADDR_W-1:0]     flash_address   = {addr_high, addr_low};
  wire [DATA_W-1:0]     flash_data_word = {data_high, data_low};
  wire [ROW_BITS-1:0]   word_sel        = flash_address[ROW_BITS-1:0];
  wire [ARRAY_BITS-1:0] arr_idx         = flash_address[ARRAY_BITS-1:0];
  wire [2:0]            row_grp         = flash_address[ARRAY_BITS-1:ARRAY_BITS-3];
  wire wr_ctl   = WR_STB && (ADDR == ADDR_CONTROL);
  wire wr_key   = WR_STB && (ADDR == ADDR_UNLOCK_KEY);
  wire wr_other = WR_STB && !wr_ctl && !wr_key;
  // start request only accepted after full key
  wire start_req = wr_ctl && WDATA[BIT_WRITE] && !write_busy;
  wire start_ok  = start_req && (key == KEY_FULL);
  // a start write also carries the mode bits: decode with the values being written
  wire ctl_take   = wr_ctl && !write_busy;
  wire cur_region = ctl_take ? WDATA[BIT_REGION] : region;
  wire cur_latch  = ctl_take ? WDATA[BIT_LATCH_ONLY] : latch_only;
  wire cur_erase  = ctl_take ? WDATA[BIT_ERASE] : erase;
  wire cur_permit = ctl_take ? WDATA[BIT_PERMIT] : permit;
  // unlock broken: any other access between the key bytes and start
  wire unlock_broken = (key != KEY_NONE) && (wr_other || RD_STB || (wr_ctl && !WDATA[BIT_WRITE]))
                       || (wr_key && key == KEY_HALF && WDATA != KEY_SECOND)
                       || (wr_key && key == KEY_FULL);
  wire in_user  = cur_region && flash_address >= USER_ID_BASE && flash_address <= USER_ID_LAST;
  wire in_ro    = cur_region && ((flash_address >= INFO_RO_BASE && flash_address <= INFO_RO_LAST)
                  || (flash_address >= DIA_BASE && flash_address <= DIA_LAST));
  // address region: info area versus array
  wire in_array = !cur_region && (flash_address < ADDR_W'(ARRAY_WORDS));
  wire row_prot = in_array && protect_rows[row_grp];
  // erase dominates latch-only
  wire op_erase = start_ok && cur_erase;
  wire op_latch = start_ok && !cur_erase && cur_latch;
  wire op_prog  = start_ok && !cur_erase && !cur_latch;
  // protected or read-only target, or program not permitted
  wire op_block = (op_erase || op_prog)
                  && (row_prot || in_ro || !cur_permit || (cur_region && !in_user));
  wire op_long  = (op_erase || op_prog) && !op_block;
  wire finish   = (state == FS_BUSY) && (timer == 8'h00);
  wire fault_set = op_block || unlock_broken || was_busy_at_reset;
  wire done_set  = finish;
  wire [DATA_W-1:0] read_word = in_array ? array_mem[arr_idx]
                              : in_user  ? user_id[flash_address[1:0]]
                              : in_ro    ? INFO_FILL
                              : '0; // invalid info address reads zero
  wire [7:0] ctl_view = {1'b0, region, latch_only, erase, fault, permit, write_busy, read_go};
  wire [7:0] next_rdata =
      (ADDR == ADDR_DATA_LOW)   ? data_low :
      (ADDR == ADDR_DATA_HIGH)  ? {2'b00, data_high} :
      (ADDR == ADDR_ADDR_LOW)   ? addr_low :
      (ADDR == ADDR_ADDR_HIGH)  ? {1'b1, addr_high} :   // top bit reads one
      (ADDR == ADDR_CONTROL)    ? ctl_view :            // bits valid only when idle
      (ADDR == ADDR_IRQ_STATUS) ? {7'h00, done_flag} :
      (ADDR == ADDR_IRQ_MASK)   ? {7'h00, done_mask} :
      (ADDR == ADDR_PROTECT)    ? protect_rows :
      8'h00;                                           // key is write-only

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      RDATA <= 8'h00;
    end else begin
      RDATA <= RD_STB ? next_rdata : 8'h00;
    end
  end

  // key tracker: 55h then AAh
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      key <= KEY_NONE;
    end else if (wr_key && WDATA == KEY_FIRST && key == KEY_NONE) begin
      key <= KEY_HALF;
    end else if (wr_key && WDATA == KEY_SECOND && key == KEY_HALF) begin
      key <= KEY_FULL;
    end else if (wr_key || wr_ctl || wr_other || RD_STB) begin
      key <= KEY_NONE;
    end
  end

  // a reset of at most two cycles during a write leaves a fault behind
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      was_busy_at_reset <= 1'b0;
    end else begin
      was_busy_at_reset <= 1'b0;
    end
  end

  logic busy_mark;
  always_ff @(posedge CLK_SYS) begin
    busy_mark <= write_busy;
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      region     <= 1'b0;
      latch_only <= 1'b0;
      erase      <= 1'b0;
      permit     <= 1'b0;
      write_busy <= 1'b0;
      read_go    <= 1'b0;
      state      <= FS_IDLE;
      timer      <= 8'h00;
    end else begin
      if (wr_ctl && !write_busy) begin
        region     <= WDATA[BIT_REGION];
        latch_only <= WDATA[BIT_LATCH_ONLY];
        erase      <= WDATA[BIT_ERASE];
        permit     <= WDATA[BIT_PERMIT];
      end
      read_go <= wr_ctl && WDATA[BIT_READ] && !write_busy; // set only, self-clears
      case (state)
        FS_IDLE: begin
          if (op_long) begin
            write_busy <= 1'b1;
            state      <= FS_BUSY;
            timer      <= PROG_COUNT;
          end
        end
        FS_BUSY: begin
          // zero writes to busy bit ignored
          if (finish) begin
            write_busy <= 1'b0;  // self-timed end
            state      <= FS_IDLE;
            if (erase) begin
              erase <= 1'b0;
            end
          end else begin
            timer <= timer - 8'h01;
          end
        end
        default: state <= FS_IDLE;
      endcase
    end
  end

  // fault: hardware sets, software clears or sets, set wins
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      fault <= busy_mark;
    end else if (fault_set) begin
      fault <= 1'b1;
    end else if (wr_ctl && !write_busy) begin
      fault <= WDATA[BIT_FAULT];
    end
  end

  // completion flag and masked interrupt
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      done_flag    <= 1'b0;
      done_mask    <= 1'b0;
      protect_rows <= 8'h00;
      IRQ          <= 1'b0;
    end else begin
      if (done_set) begin
        done_flag <= 1'b1;
      end else if (WR_STB && ADDR == ADDR_IRQ_STATUS && WDATA[0]) begin
        done_flag <= 1'b0;
      end
      if (WR_STB && ADDR == ADDR_IRQ_MASK) begin
        done_mask <= WDATA[0];
      end
      if (WR_STB && ADDR == ADDR_PROTECT) begin
        protect_rows <= WDATA;
      end
      IRQ <= (done_flag || done_set) && done_mask;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      data_low  <= 8'h00;
      data_high <= 6'h00;
      addr_low  <= 8'h00;
      addr_high <= ADDR_HIGH_FILL;
    end else begin
      if (read_go) begin
        data_low  <= read_word[7:0];
        data_high <= read_word[13:8];
      end else begin
        if (WR_STB && ADDR == ADDR_DATA_LOW) data_low <= WDATA;
        if (WR_STB && ADDR == ADDR_DATA_HIGH) data_high <= WDATA[5:0];
      end
      if (WR_STB && ADDR == ADDR_ADDR_LOW && !write_busy) addr_low <= WDATA;
      if (WR_STB && ADDR == ADDR_ADDR_HIGH && !write_busy) addr_high <= WDATA[6:0];
    end
  end

  // row latches, array and user ids
  genvar g;
  generate
    for (g = 0; g < ROW_WORDS; g++) begin : g_latch
      always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
          row_latch[g] <= LATCH_RESET;
        end else if (op_latch && word_sel == ROW_BITS'(g)) begin
          row_latch[g] <= flash_data_word;   // latch load only
        end else if (finish && !erase) begin
          row_latch[g] <= LATCH_RESET;
        end
      end
    end
  endgenerate

  always_ff @(posedge CLK_SYS) begin
    if (finish && in_array) begin
      for (int i = 0; i < ROW_WORDS; i++) begin
        array_mem[{arr_idx[ARRAY_BITS-1:ROW_BITS], ROW_BITS'(i)}] <=
          erase ? ERASED_WORD : row_latch[i];
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      for (int i = 0; i < USER_ID_WORDS; i++) user_id[i] <= INFO_FILL;
    end else if (finish && region && !erase) begin
      user_id[flash_address[1:0]] <= row_latch[word_sel];
    end
  end

  a_write_locked: assert property (@(posedge CLK_SYS) disable iff (RESET)
    $rose(write_busy) |-> $past(key) == KEY_FULL)
    else $error("write started without unlock");
  a_busy_length: assert property (@(posedge CLK_SYS) disable iff (RESET)
    $rose(write_busy) |-> write_busy [*8])
    else $error("write ended too soon");
  a_read_clears: assert property (@(posedge CLK_SYS) disable iff (RESET)
    read_go |=> !read_go)
    else $error("read bit stuck");
  a_permit_gate: assert property (@(posedge CLK_SYS) disable iff (RESET)
    $rose(write_busy) |-> permit)
    else $error("write without permit");
  a_erase_clear: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (finish && erase) |=> !erase)
    else $error("erase bit not cleared");
  a_fault_sticky: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (fault && !wr_ctl) |=> fault)
    else $error("fault cleared by hardware");
  a_done_flag: assert property (@(posedge CLK_SYS) disable iff (RESET)
    $fell(write_busy) |-> done_flag)
    else $error("done flag missing");
  a_prot_fault: assert property (@(posedge CLK_SYS) disable iff (RESET)
    op_block |=> fault && !write_busy)
    else $error("protected op not faulted");
endmodule

//--- bench/fspc_host.sv
// partner model: processor core driving the register port
module fspc_host
  import fspc_pkg::*;
(
  input  wire logic       CLK_SYS,
  output logic      [3:0] ADDR,
  output logic      [7:0] WDATA,
  output logic            WR_STB,
  output logic            RD_STB,
  input  wire logic [7:0] RDATA
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus until the first transfer
  initial begin
    ADDR   = 4'h0;
    WDATA  = 8'h00;
    WR_STB = 1'b0;
    RD_STB = 1'b0;
  end

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge CLK_SYS);
    ADDR   <= a;
    WDATA  <= d;
    WR_STB <= 1'b1;
    @(posedge CLK_SYS);
    WR_STB <= 1'b0;
    WDATA  <= ~d;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge CLK_SYS);
    ADDR   <= a;
    RD_STB <= 1'b1;
    @(posedge CLK_SYS);
    RD_STB <= 1'b0;
    #1 d = RDATA;
  endtask

  // key pair then start, nothing in between
  task automatic start(input logic [7:0] ctl);
    wr(ADDR_UNLOCK_KEY, KEY_FIRST);
    wr(ADDR_UNLOCK_KEY, KEY_SECOND);
    wr(ADDR_CONTROL, ctl | 8'h02);
  endtask
endmodule

//--- bench/tb_top.sv
// testbench: flash controller driven by the core model, checked against a word model
module tb_top
  import fspc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0;
  logic        reset   = 1'b1;
  logic [3:0]  addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic [7:0]  v;
  logic        wr_stb;
  logic        rd_stb;
  logic        irq;
  logic [13:0] w;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  int          mem[int];

  fspc_host host (.CLK_SYS(clk_sys), .ADDR(addr), .WDATA(wdata), .WR_STB(wr_stb),
                  .RD_STB(rd_stb), .RDATA(rdata));
  fspc_top uut (.CLK_SYS(clk_sys), .RESET(reset), .ADDR(addr), .WDATA(wdata),
                .WR_STB(wr_stb), .RD_STB(rd_stb), .RDATA(rdata), .IRQ(irq));

  initial begin
    forever #20 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
  end

  task automatic finish_test();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(a, d);
    check(d, exp);
  endtask

  task automatic set_addr(input logic [14:0] a);
    host.wr(ADDR_ADDR_LOW, a[7:0]);
    host.wr(ADDR_ADDR_HIGH, {1'b0, a[14:8]});
  endtask

  // poll the busy bit under a bound
  task automatic wait_idle();
    logic [7:0] d;
    for (int i = 0; i < 100; i++) begin
      host.rd(ADDR_CONTROL, d);
      if (d[BIT_WRITE] === 1'b0) break;
      if (i == 99) check(d, 8'h00);
    end
  endtask

  task automatic read_word(input logic [14:0] a, input logic [7:0] rg, input logic [13:0] e);
    set_addr(a);
    host.wr(ADDR_CONTROL, rg | 8'h01);
    rchk(ADDR_DATA_LOW, e[7:0]);
    rchk(ADDR_DATA_HIGH, {2'b00, e[13:8]});
  endtask

  initial begin
    void'($urandom(71));
    wait (reset === 1'b0);
    rchk(ADDR_ADDR_LOW, 8'h00);
    rchk(ADDR_ADDR_HIGH, 8'h80);
    rchk(ADDR_CONTROL, 8'h00);
    rchk(ADDR_UNLOCK_KEY, 8'h00);
    host.wr(ADDR_ADDR_HIGH, 8'h7F);
    rchk(ADDR_ADDR_HIGH, 8'hFF);
    host.wr(ADDR_DATA_HIGH, 8'hFF);
    rchk(ADDR_DATA_HIGH, 8'h3F);
    host.wr(ADDR_UNLOCK_KEY, KEY_FIRST);
    rchk(ADDR_UNLOCK_KEY, 8'h00);
    host.wr(ADDR_UNLOCK_KEY, KEY_SECOND);
    host.wr(ADDR_CONTROL, 8'h06);
    host.rd(ADDR_CONTROL, v);
    check(v & 8'h02, 8'h00);
    host.wr(ADDR_UNLOCK_KEY, KEY_SECOND);
    host.wr(ADDR_UNLOCK_KEY, KEY_FIRST);
    host.wr(ADDR_CONTROL, 8'h06);
    host.rd(ADDR_CONTROL, v);
    check(v & 8'h02, 8'h00);
    host.wr(ADDR_CONTROL, 8'h08);
    rchk(ADDR_CONTROL, 8'h08);
    host.wr(ADDR_CONTROL, 8'h00);
    rchk(ADDR_CONTROL, 8'h00);
    // row erase with completion interrupt
    host.wr(ADDR_IRQ_MASK, 8'h01);
    set_addr(15'h0085);
    host.start(8'h14);
    wait_idle();
    rchk(ADDR_CONTROL, 8'h04);
    for (int i = 0; i < 32; i++)
      mem[128 + i] = 'h3FFF;
    check({7'h00, irq}, 8'h01);
    host.wr(ADDR_IRQ_MASK, 8'h00);
    rchk(ADDR_IRQ_STATUS, 8'h01);
    check({7'h00, irq}, 8'h00);
    host.wr(ADDR_IRQ_STATUS, 8'h01);
    host.wr(ADDR_IRQ_MASK, 8'h01);
    rchk(ADDR_IRQ_STATUS, 8'h00);
    check({7'h00, irq}, 8'h00);
    // latch loads, then one row program
    for (int k = 0; k < 4; k++) begin
      w = 14'($urandom);
      mem[128 + 9 * k] = w;
      set_addr(15'(128 + 9 * k));
      host.wr(ADDR_DATA_LOW, w[7:0]);
      host.wr(ADDR_DATA_HIGH, {2'b00, w[13:8]});
      host.start(8'h24);
      wait_idle();
    end
    read_word(15'h0080, 8'h00, 14'h3FFF);
    for (int i = 0; i < 32; i++)
      if (i % 9 != 0) mem[128 + i] = 'h03FF;
    set_addr(15'h0080);
    host.start(8'h04);
    host.wr(ADDR_CONTROL, 8'h04);
    host.rd(ADDR_CONTROL, v);
    check(v & 8'h02, 8'h02);
    wait_idle();
    for (int i = 0; i < 10; i++)
      read_word(15'(128 + i), 8'h00, 14'(mem[128 + i]));
    set_addr(15'h0089);
    host.start(8'h10);
    wait_idle();
    read_word(15'h0089, 8'h00, 14'(mem[137]));
    read_word(15'h0089, 8'h40, 14'h0000);
    // protected group faults
    host.wr(ADDR_PROTECT, 8'h01);
    set_addr(15'h0010);
    host.start(8'h14);
    wait_idle();
    host.rd(ADDR_CONTROL, v);
    check(v & 8'h0A, 8'h08);
    // reset in mid-write
    host.wr(ADDR_CONTROL, 8'h00);
    set_addr(15'h00A0);
    host.start(8'h14);
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    host.rd(ADDR_CONTROL, v);
    check(v & 8'h0A, 8'h08);
    finish_test();
  end
endmodule
